// ### design/host_port_pkg.sv
// Purpose: Shared constants and types for the host port block.
// Assumes: AHB-Lite register access, 32-bit data, word aligned.
// Notes: Memory window is a small on-chip array behind the port.
package host_port_pkg;

  localparam int MEM_DEPTH = 256;
  localparam int MEM_AW = 8;

  // Host register select codes, four codes reach three registers
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_DATA_INC = 2'h1;
  localparam logic [1:0] SEL_ADDR = 2'h2;
  localparam logic [1:0] SEL_DATA = 2'h3;

  // AHB register byte offsets
  localparam logic [7:0] OFF_BANK_SWITCH_CONTROL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_HADDR = 8'h08;

  // Bank-switch control fields
  localparam int BANK_SWITCH_CONTROL_KEEP_BIT = 0;
  localparam int BANK_SWITCH_CONTROL_DIR_LSB = 8;
  localparam int BANK_SWITCH_CONTROL_OUT_LSB = 16;
  localparam logic [31:0] BANK_SWITCH_CONTROL_RESET = 32'h0000_0000;

  // Status fields
  localparam int STAT_EN_BIT = 0;
  localparam int STAT_WIDE_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_GPIO_LSB = 8;

  // Host control register: byte order bit, 1 puts the low byte first
  localparam int HCTRL_ORDER_BIT = 0;
  localparam logic HCTRL_RESET = 1'b0;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef struct packed {
    logic [1:0] reg_sel;
    logic byte_second;
    logic rw_read;
  } host_ctl_s;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ACCESS = 2'b01,
    PH_RECOVER = 2'b10
  } phase_e;

endpackage

// ### design/host_port.sv
// Purpose: Device side of the parallel host port, byte and wide forms.
// Assumes: Host pins are synchronous to hclk; hresetn is the device reset.
// Notes: Reads act at strobe start, writes at strobe end.
// Contract
// - Wide mode takes the access address from the sixteen external address lines.
// - Wide mode reads and writes memory over the sixteen external data lines.
// - Wide data lines float when idle, in reset, on hold request, or tristate low.
// - Host byte bus floats when not outputting or when tristate input is low.
// - Wide mode turns the host byte bus into general-purpose pins.
// - Enabled keepers hold the byte bus at its last data-transfer level, in byte mode only.
// - Keepers are off after reset; a control bit switches them.
// - Two select inputs choose one of three host registers.
// - Byte flag marks first or second byte; unused in wide mode.
// - Data strobes time each transfer.
// - Address strobe latches the presented byte into the host address register.
// - Read/write input sets each transfer's direction.
// - Ready output shows when the next transfer may start; floats when tristate low.
// - Enable input sampled as reset releases; disabled until the next reset.
// - Wide mode has no host control or address register.
`timescale 1ns/1ps
`default_nettype none
module host_port
  import host_port_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic off_n,
  input wire logic hold_req,
  input wire logic wide_mode_select,
  input wire logic host_port_enable,
  input wire logic [15:0] ext_address_lines,
  input wire logic [15:0] ext_data_in,
  output logic [15:0] ext_data_out,
  output logic ext_data_oe,
  input wire logic [7:0] host_byte_in,
  output logic [7:0] host_byte_out,
  output logic [7:0] host_byte_oe,
  output logic host_byte_keep,
  input wire host_ctl_s host_ctl,
  input wire logic host_select_n,
  input wire logic host_strobe_a,
  input wire logic host_strobe_b,
  input wire logic host_addr_strobe_n,
  output logic host_ready_out,
  output logic host_ready_oe
);

  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic second, input logic order);
    pick_byte = (second ^ order) ? w[7:0] : w[15:8];
  endfunction

  function automatic logic [15:0] put_byte(input logic [15:0] w, input logic [7:0] b, input logic second,
                                           input logic order);
    put_byte = (second ^ order) ? {w[15:8], b} : {b, w[7:0]};
  endfunction

  function automatic logic [MEM_AW-1:0] mem_idx(input logic [15:0] a);
    mem_idx = a[MEM_AW-1:0];
  endfunction

  logic [15:0] mem [MEM_DEPTH];

  // Reset strap capture
  logic sampled_r;
  logic port_en_r;

  // Host port state
  phase_e phase_r, phase_nxt;
  host_ctl_s ctl_r, ctl_nxt;
  logic [15:0] hpa_r, hpa_nxt;
  logic [15:0] word_r, word_nxt;
  logic [7:0] wlat_r, wlat_nxt;
  logic order_r, order_nxt;
  logic [7:0] bout_r, bout_nxt;
  logic drive_r, drive_nxt;
  logic [15:0] dout_r, dout_nxt;
  logic eoe_r, eoe_nxt;
  logic as_q_r, as_q_nxt;
  logic mem_we;
  logic [MEM_AW-1:0] mem_wa;
  logic [15:0] mem_wd;

  // Bus slave state
  logic [31:0] bank_switch_control_r, bank_switch_control_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [7:0] aaddr_r, aaddr_nxt;
  logic awr_r, awr_nxt;

  logic wide;
  logic strobe_act;
  logic as_fall;
  logic keep_en;
  logic [15:0] wide_word;
  logic [15:0] hpa_word;

  assign wide = wide_mode_select;
  // Strobe is active while either data strobe is low under a select
  assign strobe_act = port_en_r && !host_select_n && !(host_strobe_a && host_strobe_b);
  assign as_fall = as_q_r && !host_addr_strobe_n;
  assign keep_en = bank_switch_control_r[BANK_SWITCH_CONTROL_KEEP_BIT];
  assign wide_word = mem[mem_idx(ext_address_lines)];
  assign hpa_word = mem[mem_idx(hpa_r)];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sampled_r <= 1'b0;
      port_en_r <= 1'b0;
    end else if (ce && !sampled_r) begin
      sampled_r <= 1'b1;
      port_en_r <= host_port_enable;
    end
  end

  always_comb begin
    phase_nxt = phase_r;
    ctl_nxt = ctl_r;
    hpa_nxt = hpa_r;
    word_nxt = word_r;
    wlat_nxt = wlat_r;
    order_nxt = order_r;
    bout_nxt = bout_r;
    drive_nxt = drive_r;
    dout_nxt = dout_r;
    eoe_nxt = eoe_r;
    as_q_nxt = host_addr_strobe_n;
    mem_we = 1'b0;
    mem_wa = mem_idx(hpa_r);
    mem_wd = ext_data_in;
    unique case (phase_r)
      PH_IDLE: begin
        if (strobe_act) begin
          phase_nxt = PH_ACCESS;
          ctl_nxt = host_ctl;
          if (host_ctl.rw_read && wide) begin
            dout_nxt = wide_word;
            eoe_nxt = 1'b1;
          end else if (host_ctl.rw_read) begin
            drive_nxt = 1'b1;
            unique case (host_ctl.reg_sel)
              SEL_CTRL: bout_nxt = {7'h00, order_r};
              SEL_ADDR: bout_nxt = pick_byte(hpa_r, host_ctl.byte_second, order_r);
              default: begin
                if (!host_ctl.byte_second) begin
                  word_nxt = hpa_word;
                  bout_nxt = pick_byte(hpa_word, 1'b0, order_r);
                end else begin
                  bout_nxt = pick_byte(word_r, 1'b1, order_r);
                end
              end
            endcase
          end
        end
      end
      PH_ACCESS: begin
        if (!strobe_act) begin
          phase_nxt = PH_RECOVER;
          drive_nxt = 1'b0;
          eoe_nxt = 1'b0;
          if (wide) begin
            if (!ctl_r.rw_read) begin
              mem_we = 1'b1;
              mem_wa = mem_idx(ext_address_lines);
            end
          end else begin
            if (!ctl_r.rw_read) begin
              bout_nxt = host_byte_in;
              unique case (ctl_r.reg_sel)
                SEL_CTRL: order_nxt = host_byte_in[HCTRL_ORDER_BIT];
                SEL_ADDR: hpa_nxt = put_byte(hpa_r, host_byte_in, ctl_r.byte_second, order_r);
                default: begin
                  if (!ctl_r.byte_second) begin
                    wlat_nxt = host_byte_in;
                  end else begin
                    mem_we = 1'b1;
                    mem_wd = put_byte(put_byte(16'h0000, wlat_r, 1'b0, order_r), host_byte_in, 1'b1, order_r);
                  end
                end
              endcase
            end
            if (ctl_r.reg_sel == SEL_DATA_INC && ctl_r.byte_second) begin
              hpa_nxt = hpa_r + 16'h0001;
            end
          end
        end
      end
      PH_RECOVER: phase_nxt = PH_IDLE;
      default: phase_nxt = PH_IDLE;
    endcase
    // Multiplexed hosts present the address a byte at a time
    if (as_fall && port_en_r && !wide) begin
      hpa_nxt = put_byte(hpa_r, host_byte_in, host_ctl.byte_second, 1'b0);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_r <= PH_IDLE;
      ctl_r <= '0;
      hpa_r <= 16'h0000;
      word_r <= 16'h0000;
      wlat_r <= 8'h00;
      order_r <= HCTRL_RESET;
      bout_r <= 8'h00;
      drive_r <= 1'b0;
      dout_r <= 16'h0000;
      eoe_r <= 1'b0;
      as_q_r <= 1'b1;
    end else if (ce) begin
      phase_r <= phase_nxt;
      ctl_r <= ctl_nxt;
      hpa_r <= hpa_nxt;
      word_r <= word_nxt;
      wlat_r <= wlat_nxt;
      order_r <= order_nxt;
      bout_r <= bout_nxt;
      drive_r <= drive_nxt;
      dout_r <= dout_nxt;
      eoe_r <= eoe_nxt;
      as_q_r <= as_q_nxt;
    end
  end

  always_ff @(posedge hclk) begin
    if (ce && mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Bus slave: zero wait states, registered read data
  always_comb begin
    bank_switch_control_nxt = bank_switch_control_r;
    rdata_nxt = rdata_r;
    aaddr_nxt = aaddr_r;
    awr_nxt = 1'b0;
    if (awr_r && aaddr_r == OFF_BANK_SWITCH_CONTROL) begin
      bank_switch_control_nxt = hwdata;
    end
    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      aaddr_nxt = haddr[7:0];
      awr_nxt = hwrite;
      rdata_nxt = 32'h0000_0000;
      if (!hwrite) begin
        unique case (haddr[7:0])
          OFF_BANK_SWITCH_CONTROL: rdata_nxt = bank_switch_control_nxt;
          OFF_STATUS: begin
            rdata_nxt[STAT_EN_BIT] = port_en_r;
            rdata_nxt[STAT_WIDE_BIT] = wide;
            rdata_nxt[STAT_BUSY_BIT] = phase_r != PH_IDLE;
            rdata_nxt[STAT_GPIO_LSB +: 8] = host_byte_in;
          end
          OFF_HADDR: rdata_nxt[15:0] = hpa_r;
          default: rdata_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bank_switch_control_r <= BANK_SWITCH_CONTROL_RESET;
      rdata_r <= 32'h0000_0000;
      aaddr_r <= 8'h00;
      awr_r <= 1'b0;
    end else if (ce) begin
      bank_switch_control_r <= bank_switch_control_nxt;
      rdata_r <= rdata_nxt;
      aaddr_r <= aaddr_nxt;
      awr_r <= awr_nxt;
    end
  end

  assign hrdata = rdata_r;
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;

  assign ext_data_out = dout_r;
  assign ext_data_oe = eoe_r && wide && hresetn && !hold_req && off_n;
  assign host_byte_out = wide ? bank_switch_control_r[BANK_SWITCH_CONTROL_OUT_LSB +: 8] : bout_r;
  assign host_byte_oe = !off_n ? 8'h00 :
                        wide ? bank_switch_control_r[BANK_SWITCH_CONTROL_DIR_LSB +: 8] : {8{drive_r}};
  assign host_byte_keep = keep_en && !wide && !drive_r;
  assign host_ready_out = phase_r == PH_IDLE;
  assign host_ready_oe = off_n && port_en_r;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ext_float_a: assert property ((hold_req || !off_n || !eoe_r) |-> !ext_data_oe)
    else $error("wide data lines driven while they must float");
  byte_float_a: assert property (!off_n |-> host_byte_oe == 8'h00)
    else $error("byte bus driven while tristate input low");
  ready_float_a: assert property (!off_n |-> !host_ready_oe)
    else $error("ready output driven while tristate input low");
  gpio_mode_a: assert property (wide |-> host_byte_out == bank_switch_control_r[BANK_SWITCH_CONTROL_OUT_LSB +: 8])
    else $error("byte bus not serving as general pins in wide mode");
  keeper_reset_a: assert property (!sampled_r |-> !keep_en && !host_byte_keep)
    else $error("keepers enabled straight after reset");
  strap_hold_a: assert property (sampled_r |=> $stable(port_en_r))
    else $error("port enable changed after the reset strap");
  port_off_a: assert property (!port_en_r && sampled_r |-> phase_r == PH_IDLE && !drive_r)
    else $error("disabled port started an access");
  wide_read_a: assert property ((ce && phase_r == PH_IDLE && strobe_act && wide && host_ctl.rw_read)
    |=> eoe_r && dout_r == $past(wide_word))
    else $error("wide read did not return the addressed word");
  ctrl_read_a: assert property ((ce && phase_r == PH_IDLE && strobe_act && !wide && host_ctl.rw_read
    && host_ctl.reg_sel == SEL_CTRL) |=> drive_r && host_byte_out == {7'h00, $past(order_r)})
    else $error("control register read returned wrong byte");
  addr_latch_a: assert property ((ce && as_fall && port_en_r && !wide && !host_ctl.byte_second)
    |=> hpa_r[15:8] == $past(host_byte_in))
    else $error("address strobe did not latch the first byte");
  wide_noaddr_a: assert property ((wide && phase_r == PH_IDLE && !strobe_act) |=> $stable(hpa_r))
    else $error("host address register moved in wide mode");

endmodule
`default_nettype wire

// ### tb/host_model.sv
// Purpose: Behavioural external host on the parallel host port.
// Assumes: Pins change just after a rising hclk edge.
// Notes: Reads use strobe a, writes strobe b; slow stretches the strobe.
`timescale 1ns/1ps
`default_nettype none
module host_model
  import host_port_pkg::*;
(
  input wire logic hclk,
  input wire logic wide,
  input wire logic [7:0] byte_out,
  input wire logic [7:0] byte_oe,
  input wire logic [15:0] ext_out,
  input wire logic ext_oe,
  output var host_ctl_s ctl,
  output logic sel_n,
  output logic stb_a,
  output logic stb_b,
  output logic as_n,
  output logic drv,
  output logic [15:0] dv,
  output logic [15:0] addr
);
  initial begin
    ctl = '0;
    sel_n = 1'b1;
    stb_a = 1'b1;
    stb_b = 1'b1;
    as_n = 1'b1;
    drv = 1'b0;
    dv = 16'h0000;
    addr = 16'h0000;
  end

  task automatic xfer(input logic [1:0] rs, input logic sec, input logic rd, input logic [15:0] d,
                      input logic [15:0] a, input int slow, output logic [31:0] q);
    ctl <= '{rs, sec, rd};
    sel_n <= 1'b0;
    stb_a <= !rd;
    stb_b <= rd;
    drv <= !rd;
    dv <= d;
    addr <= a;
    repeat (2 + slow) @(posedge hclk);
    q = wide ? {15'h0, ext_oe, ext_out} : {16'h0, byte_oe, byte_out};
    stb_a <= 1'b1;
    stb_b <= 1'b1;
    @(posedge hclk);
    // Write data held past the strobe release edge
    sel_n <= 1'b1;
    drv <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask

  task automatic astrobe(input logic sec, input logic [7:0] b);
    ctl.byte_second <= sec;
    dv <= {8'h00, b};
    drv <= 1'b1;
    sel_n <= 1'b0;
    as_n <= 1'b0;
    repeat (2) @(posedge hclk);
    as_n <= 1'b1;
    sel_n <= 1'b1;
    @(posedge hclk);
    drv <= 1'b0;
    @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// ### tb/test_host_port_pin_interface.sv
// Purpose: Self-checking bench for the host port block.
// Assumes: Single host, AHB-Lite register master in the bench.
// Notes: Released lines show a changing pattern unless kept.
`timescale 1ns/1ps
`default_nettype none
module test_host_port_pin_interface;
  import host_port_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, off_n = 1, hold_req = 0, wide = 0, pen = 1;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, ext_data_oe, host_byte_keep, host_ready_out, host_ready_oe;
  logic sel_n, stb_a, stb_b, as_n, drv;
  logic [15:0] ext_data_in, ext_data_out, dv, addr, d;
  logic [7:0] host_byte_in, host_byte_out, host_byte_oe, cnt = 0, a;
  host_ctl_s ctl;
  logic [31:0] exp_q[$], seen_q[$];
  int mismatches = 0, n_tests = 0, cyc = 0;

  always #2.5 hclk = ~hclk;
  always @(posedge hclk) cnt <= cnt + 8'h01;
  assign host_byte_in = (host_byte_oe & host_byte_out) |
                        (~host_byte_oe & (drv ? dv[7:0] : host_byte_keep ? host_byte_out : cnt));
  assign ext_data_in = ext_data_oe ? ext_data_out : drv ? dv : {cnt, ~cnt};

  host_port uut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .off_n(off_n), .hold_req(hold_req), .wide_mode_select(wide),
    .host_port_enable(pen), .ext_address_lines(addr), .ext_data_in(ext_data_in),
    .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe), .host_byte_in(host_byte_in),
    .host_byte_out(host_byte_out), .host_byte_oe(host_byte_oe), .host_byte_keep(host_byte_keep),
    .host_ctl(ctl), .host_select_n(sel_n), .host_strobe_a(stb_a), .host_strobe_b(stb_b),
    .host_addr_strobe_n(as_n), .host_ready_out(host_ready_out), .host_ready_oe(host_ready_oe));

  host_model host (.hclk(hclk), .wide(wide), .byte_out(host_byte_out), .byte_oe(host_byte_oe),
    .ext_out(ext_data_out), .ext_oe(ext_data_oe), .ctl(ctl), .sel_n(sel_n), .stb_a(stb_a),
    .stb_b(stb_b), .as_n(as_n), .drv(drv), .dv(dv), .addr(addr));

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic expect_v(input logic [31:0] s, input logic [31:0] e);
    exp_q.push_back(e);
    seen_q.push_back(s);
  endtask

  initial forever begin
    wait (seen_q.size() > 0);
    check(seen_q.pop_front(), exp_q.pop_front());
  end

  task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rq);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rq = hrdata;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] rq;
    ahb(1'b0, ad, 32'h0, rq);
    expect_v(rq & m, e);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    logic [31:0] rq;
    ahb(1'b1, ad, wd, rq);
  endtask

  task automatic end_of_test;
    #1;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test;
    end
  end

  initial begin
    void'($urandom(32'h3b58));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rd(OFF_BANK_SWITCH_CONTROL, 32'hffffffff, BANK_SWITCH_CONTROL_RESET);
    rd(OFF_STATUS, 32'h7, 32'h1);
    expect_v({31'h0, host_byte_keep}, 32'h0);
    expect_v({30'h0, hresp, host_ready_out}, {30'h0, HRESP_OKAY, 1'b1});
    $display("test done: reset");
    a = 8'($urandom_range(0, 200));
    d = 16'($urandom);
    host.astrobe(1'b0, 8'h00);
    host.astrobe(1'b1, a);
    rd(OFF_HADDR, 32'hffff, {24'h0, a});
    wr(OFF_BANK_SWITCH_CONTROL, 32'h1);
    host.xfer(SEL_CTRL, 1'b0, 1'b0, 16'h0, 16'h0, 0, q);
    host.xfer(SEL_CTRL, 1'b1, 1'b0, 16'h0, 16'h0, 0, q);
    host.xfer(SEL_DATA_INC, 1'b0, 1'b0, {8'h0, d[15:8]}, 16'h0, 1, q);
    host.xfer(SEL_DATA_INC, 1'b1, 1'b0, {8'h0, d[7:0]}, 16'h0, 0, q);
    rd(OFF_HADDR, 32'hffff, {24'h0, a} + 32'h1);
    host.xfer(SEL_DATA, 1'b0, 1'b0, {8'h0, ~d[15:8]}, 16'h0, 0, q);
    host.xfer(SEL_DATA, 1'b1, 1'b0, {8'h0, ~d[7:0]}, 16'h0, 2, q);
    host.xfer(SEL_ADDR, 1'b0, 1'b0, 16'h0, 16'h0, 0, q);
    host.xfer(SEL_ADDR, 1'b1, 1'b0, {8'h0, a}, 16'h0, 0, q);
    host.xfer(SEL_DATA_INC, 1'b0, 1'b1, 16'h0, 16'h0, 3, q);
    expect_v(q, {16'h0, 8'hff, d[15:8]});
    host.xfer(SEL_DATA_INC, 1'b1, 1'b1, 16'h0, 16'h0, 0, q);
    expect_v(q, {16'h0, 8'hff, d[7:0]});
    expect_v({31'h0, host_byte_keep}, 32'h1);
    host.xfer(SEL_DATA, 1'b0, 1'b1, 16'h0, 16'h0, 0, q);
    expect_v(q, {16'h0, 8'hff, ~d[15:8]});
    host.xfer(SEL_DATA, 1'b1, 1'b1, 16'h0, 16'h0, 0, q);
    expect_v(q, {16'h0, 8'hff, ~d[7:0]});
    // Order bit set: low byte comes first
    host.xfer(SEL_CTRL, 1'b0, 1'b0, 16'h1, 16'h0, 0, q);
    host.xfer(SEL_CTRL, 1'b0, 1'b1, 16'h0, 16'h0, 0, q);
    expect_v(q, 32'h0000ff01);
    host.xfer(SEL_ADDR, 1'b0, 1'b1, 16'h0, 16'h0, 0, q);
    expect_v(q, {16'h0, 8'hff, a + 8'h01});
    wr(OFF_BANK_SWITCH_CONTROL, 32'h0);
    @(posedge hclk);
    expect_v({31'h0, host_byte_keep}, 32'h0);
    $display("test done: byte mode");
    off_n <= 1'b0;
    host.xfer(SEL_DATA, 1'b0, 1'b1, 16'h0, 16'h0, 0, q);
    expect_v(q & 32'hff00, 32'h0);
    expect_v({30'h0, host_ready_oe, ext_data_oe}, 32'h0);
    off_n <= 1'b1;
    $display("test done: tristate");
    wide <= 1'b1;
    d = 16'($urandom);
    host.xfer(SEL_CTRL, 1'b0, 1'b0, d, {8'h0, a}, 0, q);
    host.xfer(SEL_CTRL, 1'b0, 1'b1, 16'h0, {8'h0, a}, 1, q);
    expect_v(q, {15'h0, 1'b1, d});
    hold_req <= 1'b1;
    host.xfer(SEL_CTRL, 1'b0, 1'b1, 16'h0, {8'h0, a}, 0, q);
    expect_v(q & 32'h10000, 32'h0);
    hold_req <= 1'b0;
    host.astrobe(1'b1, ~a);
    rd(OFF_HADDR, 32'hffff, {24'h0, a} + 32'h1);
    wr(OFF_BANK_SWITCH_CONTROL, 32'h00a5ff00);
    @(posedge hclk);
    expect_v({16'h0, host_byte_oe, host_byte_out}, 32'hffa5);
    $display("test done: wide mode");
    wide <= 1'b0;
    hresetn <= 1'b0;
    pen <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    pen <= 1'b1;
    rd(OFF_STATUS, 32'h1, 32'h0);
    expect_v({31'h0, host_ready_oe}, 32'h0);
    $display("test done: disabled port");
    end_of_test;
  end
endmodule
`default_nettype wire
